// ===== idst_cmd.sv
`timescale 1ns/1ps
`include "idst_regs.svh"

// How it works
// - E3h and 97h both mean idle
// - idle now, load countdown, start counting
// - spin up only when spindle stopped
// - idle keeps spindle turning, no delay
// - timeout code zero disables standby timer
// - codes 1-240 x5s, 241-251 x30min
// - 252 21min, 253 8h, 255 21m15s
// - expiry without access forces standby
// - host access reloads full interval
// - word 255: A5 plus negated checksum
// - word 209 reads 4000H
// - word 222 reads 107FH, serial transport
// - word 223 reads 0021H
// - word 217 gives selected rotation rate
// - word 234 reads 0008H, 235 zero
// - words 230-233 hold extended sector count
// - unsupported feature words read zero
module idst_cmd #(
    parameter int TICK_CYCLES = `IDST_TICK_SEC * `IDST_CLK_HZ
) (
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              cmdValid,
    input  wire idst_pkg::idst_tf_t cmdIn,
    input  wire logic              hostAccess,
    input  wire logic              spindleSpinning,
    input  wire logic [7:0]        regAddr,
    input  wire logic [31:0]       regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic [31:0]            regRdata,
    input  wire logic [7:0]        idAddr,
    input  wire logic              idRd,
    output logic [15:0]            idData,
    output logic [7:0]             tfStatus,
    output logic [7:0]             tfError,
    output logic                   cmdDone,
    output logic                   spinUpStart,
    output logic                   motorOn,
    output logic                   idleMode,
    output logic                   irq
);

    idst_pkg::idst_state_t cur;
    idst_pkg::idst_state_t next_cur;

    logic        isIdleCmd;
    logic        isReject;
    logic        tick;
    logic [14:0] newLoad;
    logic [7:0]  checksum;
    logic [2:0]  events;

    // timeout code to seconds; 254 decodes to zero and its result goes unused
    function automatic logic [14:0] decodeTimeout(input logic [7:0] code);
        int secs;
        secs = 0;
        if (code == `IDST_TO_OFF) begin
            secs = 0;
        end else if (code <= `IDST_TO_STEP_MAX) begin
            secs = int'(code) * `IDST_STEP_SEC;
        end else if (code <= `IDST_TO_HALF_MAX) begin
            secs = (int'(code) - int'(`IDST_TO_STEP_MAX)) *
                   `IDST_HALF_MIN * `IDST_SEC_PER_MIN;
        end else if (code == `IDST_TO_C21M) begin
            secs = `IDST_C252_MIN * `IDST_SEC_PER_MIN;
        end else if (code == `IDST_TO_C8H) begin
            secs = `IDST_C253_HOUR * `IDST_MIN_PER_HOUR *
                   `IDST_SEC_PER_MIN;
        end else if (code == `IDST_TO_C21M15) begin
            secs = `IDST_C255_MIN * `IDST_SEC_PER_MIN +
                   `IDST_C255_SEC;
        end
        return 15'(secs);
    endfunction

    function automatic logic [15:0] rotWord(input logic [1:0] sel);
        logic [15:0] w;
        w = `IDST_ROT_A;
        if (sel == 2'h1) begin
            w = `IDST_ROT_B;
        end else if (sel == 2'h2) begin
            w = `IDST_ROT_C;
        end
        return w;
    endfunction

    // words 230-233, least significant first
    function automatic logic [15:0] sectWord(input logic [1:0] idx,
                                             input logic [63:0] cnt);
        return cnt[16*idx +: 16];
    endfunction

    // byte sum of everything but the checksum byte itself
    always_comb begin
        logic [7:0] sum;
        logic [63:0] sect;
        logic [15:0] rot;
        sect = {cur.sectHi, cur.sectLo};
        rot  = rotWord(cur.rateSel);
        sum  = cur.preSum;
        sum  = sum + 8'(`IDST_W_ALIGN >> 8) + 8'(`IDST_W_ALIGN);
        sum  = sum + rot[15:8] + rot[7:0];
        sum  = sum + 8'(`IDST_W_TMAJOR >> 8) + 8'(`IDST_W_TMAJOR);
        sum  = sum + 8'(`IDST_W_TMINOR >> 8) + 8'(`IDST_W_TMINOR);
        sum  = sum + 8'(`IDST_W_DLMIN >> 8) + 8'(`IDST_W_DLMIN);
        for (int i = 0; i < 8; i++) begin
            sum = sum + sect[8*i +: 8];
        end
        sum = sum + `IDST_SIGNATURE;
        checksum = 8'(-sum);
    end

    // identify words 207-255; all others outside this block read zero
    function automatic logic [15:0] idWord(input logic [7:0] a,
                                           input idst_pkg::idst_state_t s,
                                           input logic [7:0] ck);
        logic [15:0] w;
        w = 16'h0000;
        if (a == `IDST_ID_ALIGN) begin
            w = `IDST_W_ALIGN;
        end else if (a == `IDST_ID_ROT) begin
            w = rotWord(s.rateSel);
        end else if (a == `IDST_ID_TMAJOR) begin
            w = `IDST_W_TMAJOR;
        end else if (a == `IDST_ID_TMINOR) begin
            w = `IDST_W_TMINOR;
        end else if (a >= `IDST_ID_SECT0 && a <= `IDST_ID_SECT3) begin
            w = sectWord(2'(a - `IDST_ID_SECT0),
                         {s.sectHi, s.sectLo});
        end else if (a == `IDST_ID_DLMIN) begin
            w = `IDST_W_DLMIN;
        end else if (a == `IDST_ID_INTEG) begin
            w = {ck, `IDST_SIGNATURE};
        end
        return w;
    endfunction

    // command decode: both codes are the same command
    assign isIdleCmd = cmdValid &&
                       (cmdIn.code == `IDST_CMD_IDLE ||
                        cmdIn.code == `IDST_CMD_IDLE_ALT);
    assign isReject  = isIdleCmd && cmdIn.count == `IDST_TO_ABORT;
    assign newLoad   = decodeTimeout(cmdIn.count);
    assign tick      = cur.tickCnt == 28'(TICK_CYCLES - 1);

    // all state updates
    always_comb begin
        next_cur          = cur;
        events            = 3'h0;
        next_cur.spinUp   = 1'b0;
        next_cur.cmdDone  = 1'b0;
        next_cur.rdData   = 32'h0000_0000;
        next_cur.spinMeta = spindleSpinning;
        next_cur.spinSync = cur.spinMeta;
        // free-running second divider
        next_cur.tickCnt  = tick ? 28'h000_0000 : cur.tickCnt + 28'h000_0001;

        if (isIdleCmd) begin
            next_cur.cmdDone = 1'b1;
            events[`IDST_EV_DONE] = 1'b1;
            if (isReject) begin
                // mode and timer stay as they were
                next_cur.errAbort = 1'b1;
                events[`IDST_EV_REJECT] = 1'b1;
            end else begin
                next_cur.errAbort = 1'b0;
                next_cur.mode     = idst_pkg::MODE_IDLE;
                next_cur.motorOn  = 1'b1;
                next_cur.spinUp   = !cur.spinSync;
                next_cur.timerOn  = cmdIn.count != `IDST_TO_OFF;
                next_cur.reload   = newLoad;
                next_cur.remain   = newLoad;
            end
        end else if (cur.mode == idst_pkg::MODE_IDLE && cur.timerOn) begin
            if (hostAccess) begin
                next_cur.remain = cur.reload;
            end else if (tick) begin
                if (cur.remain <= 15'h0001) begin
                    next_cur.mode    = idst_pkg::MODE_STANDBY;
                    next_cur.motorOn = 1'b0;
                    next_cur.remain  = 15'h0000;
                    events[`IDST_EV_STANDBY] = 1'b1;
                end else begin
                    next_cur.remain = cur.remain - 15'h0001;
                end
            end
        end

        // register writes; a new event beats a same-cycle clear
        if (regWr) begin
            if (regAddr == `IDST_REG_CTRL) begin
                next_cur.rateSel = regWdata[1:0];
            end else if (regAddr == `IDST_REG_IRQ_STAT) begin
                next_cur.irqStat = cur.irqStat & ~regWdata[2:0];
            end else if (regAddr == `IDST_REG_IRQ_MASK) begin
                next_cur.irqMask = regWdata[2:0];
            end else if (regAddr == `IDST_REG_SECT_LO) begin
                next_cur.sectLo = regWdata;
            end else if (regAddr == `IDST_REG_SECT_HI) begin
                next_cur.sectHi = regWdata;
            end else if (regAddr == `IDST_REG_PRESUM) begin
                next_cur.preSum = regWdata[7:0];
            end
        end
        next_cur.irqStat = next_cur.irqStat | events;

        // register reads, unmapped offsets read zero
        if (regRd) begin
            if (regAddr == `IDST_REG_CTRL) begin
                next_cur.rdData = {30'h0, cur.rateSel};
            end else if (regAddr == `IDST_REG_IRQ_STAT) begin
                next_cur.rdData = {29'h0, cur.irqStat};
            end else if (regAddr == `IDST_REG_IRQ_MASK) begin
                next_cur.rdData = {29'h0, cur.irqMask};
            end else if (regAddr == `IDST_REG_STATE) begin
                next_cur.rdData = {28'h0, cur.spinSync, cur.motorOn,
                                   cur.timerOn,
                                   cur.mode == idst_pkg::MODE_IDLE};
            end else if (regAddr == `IDST_REG_REMAIN) begin
                next_cur.rdData = {17'h0, cur.remain};
            end else if (regAddr == `IDST_REG_SECT_LO) begin
                next_cur.rdData = cur.sectLo;
            end else if (regAddr == `IDST_REG_SECT_HI) begin
                next_cur.rdData = cur.sectHi;
            end else if (regAddr == `IDST_REG_PRESUM) begin
                next_cur.rdData = {24'h0, cur.preSum};
            end
        end

        // identify read port, data one cycle later
        if (idRd) begin
            next_cur.idData = idWord(idAddr, cur, checksum);
        end
    end

    // single state register; spindle starts stopped
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cur <= '{mode: idst_pkg::MODE_STANDBY, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign regRdata    = cur.rdData;
    assign idData      = cur.idData;
    assign cmdDone     = cur.cmdDone;
    assign spinUpStart = cur.spinUp;
    assign motorOn     = cur.motorOn;
    assign idleMode    = cur.mode == idst_pkg::MODE_IDLE;
    assign tfError     = 8'(cur.errAbort) << `IDST_ERR_ABORT;
    assign tfStatus    = (8'h01 << `IDST_ST_RDY) |
                         (8'(cur.spinSync) << `IDST_ST_DSC) |
                         (8'(cur.errAbort) << `IDST_ST_ERR);
    // level interrupt, no need for edge logic downstream
    assign irq         = |(cur.irqStat & cur.irqMask);

    // checks
    sequence s_idleCmd;
        isIdleCmd && !isReject;
    endsequence

    sequence s_timedIdle;
        cur.mode == idst_pkg::MODE_IDLE && cur.timerOn && !cmdValid;
    endsequence

    property p_codes;
        @(posedge ref_clk) disable iff (!rstn)
        s_idleCmd |=> idleMode && motorOn && cmdDone;
    endproperty
    a_codes: assert property (p_codes)
        else $error("idle command did not enter idle");

    property p_load;
        logic [7:0] c;
        @(posedge ref_clk) disable iff (!rstn)
        (s_idleCmd, c = cmdIn.count) |=>
            cur.remain == decodeTimeout(c) && cur.reload == cur.remain;
    endproperty
    a_load: assert property (p_load)
        else $error("countdown not loaded from timeout code");

    property p_spin;
        @(posedge ref_clk) disable iff (!rstn)
        s_idleCmd |=> spinUpStart == !$past(cur.spinSync) ##1 !spinUpStart;
    endproperty
    a_spin: assert property (p_spin)
        else $error("spin-up request wrong");

    property p_keepSpin;
        @(posedge ref_clk) disable iff (!rstn)
        idleMode |-> motorOn;
    endproperty
    a_keepSpin: assert property (p_keepSpin)
        else $error("motor off while idle");

    property p_zeroOff;
        @(posedge ref_clk) disable iff (!rstn)
        s_idleCmd and (cmdIn.count == `IDST_TO_OFF) |=> !cur.timerOn;
    endproperty
    a_zeroOff: assert property (p_zeroOff)
        else $error("timer enabled by code zero");

    property p_decode;
        @(posedge ref_clk) disable iff (!rstn)
        s_idleCmd and (cmdIn.count == 8'h01) |=> cur.remain == 15'h0005;
    endproperty
    a_decode: assert property (p_decode)
        else $error("code 1 not five seconds");

    property p_code255;
        @(posedge ref_clk) disable iff (!rstn)
        s_idleCmd and (cmdIn.count == `IDST_TO_C21M15)
            |=> cur.remain == 15'h04FB;
    endproperty
    a_code255: assert property (p_code255)
        else $error("code 255 not 1275 seconds");

    property p_expire;
        @(posedge ref_clk) disable iff (!rstn)
        s_timedIdle and (tick && !hostAccess && cur.remain == 15'h0001)
            |=> !idleMode && !motorOn && cur.irqStat[`IDST_EV_STANDBY];
    endproperty
    a_expire: assert property (p_expire)
        else $error("no standby at expiry");

    property p_reload;
        @(posedge ref_clk) disable iff (!rstn)
        s_timedIdle and hostAccess |=> cur.remain == $past(cur.reload);
    endproperty
    a_reload: assert property (p_reload)
        else $error("host access did not reload countdown");

    property p_signature;
        @(posedge ref_clk) disable iff (!rstn)
        idRd && idAddr == `IDST_ID_INTEG |=>
            idData == {$past(checksum), `IDST_SIGNATURE};
    endproperty
    a_signature: assert property (p_signature)
        else $error("word 255 wrong");

    property p_align;
        @(posedge ref_clk) disable iff (!rstn)
        idRd && idAddr == `IDST_ID_ALIGN |=> idData == `IDST_W_ALIGN;
    endproperty
    a_align: assert property (p_align)
        else $error("word 209 wrong");

    property p_tmajor;
        @(posedge ref_clk) disable iff (!rstn)
        idRd && idAddr == `IDST_ID_TMAJOR |=> idData == `IDST_W_TMAJOR;
    endproperty
    a_tmajor: assert property (p_tmajor)
        else $error("word 222 wrong");

    property p_tminor;
        @(posedge ref_clk) disable iff (!rstn)
        idRd && idAddr == `IDST_ID_TMINOR |=> idData == `IDST_W_TMINOR;
    endproperty
    a_tminor: assert property (p_tminor)
        else $error("word 223 wrong");

    property p_reject;
        @(posedge ref_clk) disable iff (!rstn)
        isReject |=> tfError[`IDST_ERR_ABORT] && tfStatus[`IDST_ST_ERR] &&
                     $stable(cur.mode) && $stable(cur.remain) && !spinUpStart;
    endproperty
    a_reject: assert property (p_reject)
        else $error("code 254 not rejected");

endmodule

// ===== idst_regs.svh
`ifndef IDST_REGS_SVH
`define IDST_REGS_SVH

// command codes and timeout codes
`define IDST_CMD_IDLE      8'hE3
`define IDST_CMD_IDLE_ALT  8'h97
`define IDST_TO_OFF        8'h00
`define IDST_TO_STEP_MAX   8'hF0
`define IDST_TO_HALF_MAX   8'hFB
`define IDST_TO_C21M       8'hFC
`define IDST_TO_C8H        8'hFD
`define IDST_TO_ABORT      8'hFE
`define IDST_TO_C21M15     8'hFF

// interval figures in their own units
`define IDST_STEP_SEC      5
`define IDST_HALF_MIN      30
`define IDST_C252_MIN      21
`define IDST_C253_HOUR     8
`define IDST_C255_MIN      21
`define IDST_C255_SEC      15
`define IDST_SEC_PER_MIN   60
`define IDST_MIN_PER_HOUR  60

// one-second tick at the core clock
`define IDST_TICK_SEC      1
`define IDST_CLK_HZ        200000000

// register offsets
`define IDST_REG_CTRL      8'h00
`define IDST_REG_IRQ_STAT  8'h04
`define IDST_REG_IRQ_MASK  8'h08
`define IDST_REG_STATE     8'h0C
`define IDST_REG_REMAIN    8'h10
`define IDST_REG_SECT_LO   8'h14
`define IDST_REG_SECT_HI   8'h18
`define IDST_REG_PRESUM    8'h1C

// interrupt bit positions
`define IDST_EV_DONE       0
`define IDST_EV_REJECT     1
`define IDST_EV_STANDBY    2

// identify word numbers and fixed contents
`define IDST_ID_FIRST      8'hCF
`define IDST_ID_ALIGN      8'hD1
`define IDST_ID_ROT        8'hD9
`define IDST_ID_TMAJOR     8'hDE
`define IDST_ID_TMINOR     8'hDF
`define IDST_ID_SECT0      8'hE6
`define IDST_ID_SECT3      8'hE9
`define IDST_ID_DLMIN      8'hEA
`define IDST_ID_INTEG      8'hFF
`define IDST_W_ALIGN       16'h4000
`define IDST_W_TMAJOR      16'h107F
`define IDST_W_TMINOR      16'h0021
`define IDST_W_DLMIN       16'h0008
`define IDST_ROT_A         16'h1C20
`define IDST_ROT_B         16'h1644
`define IDST_ROT_C         16'h1734
`define IDST_SIGNATURE     8'hA5

// task-file status and error bits
`define IDST_ERR_ABORT     2
`define IDST_ST_ERR        0
`define IDST_ST_DSC        4
`define IDST_ST_RDY        6

`endif

// ===== idst_pkg.sv
package idst_pkg;

    typedef enum logic [1:0] {
        MODE_STANDBY,
        MODE_IDLE
    } idst_mode_t;

    // command as latched from the task file
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] count;
    } idst_tf_t;

    typedef struct packed {
        idst_mode_t  mode;
        logic        timerOn;
        logic [14:0] remain;
        logic [14:0] reload;
        logic [27:0] tickCnt;
        logic        spinUp;
        logic        motorOn;
        logic        errAbort;
        logic        cmdDone;
        logic [2:0]  irqStat;
        logic [2:0]  irqMask;
        logic [1:0]  rateSel;
        logic [31:0] sectLo;
        logic [31:0] sectHi;
        logic [7:0]  preSum;
        logic [31:0] rdData;
        logic [15:0] idData;
        logic        spinMeta;
        logic        spinSync;
    } idst_state_t;

endpackage

// ===== idst_host_model.sv
`timescale 1ns/1ps

// host side of the task file: issues idle commands and drive accesses
module idst_host_model (
    input  wire logic               ref_clk,
    output idst_pkg::idst_tf_t      cmdIn,
    output logic                    cmdValid,
    output logic                    hostAccess
);
    // quiet lines at time zero
    initial begin
        cmdValid = 1'b0;
        cmdIn = '0;
        hostAccess = 1'b0;
    end

    // one-cycle strobe; code and count held beside it until the edge
    task automatic issue(input logic [7:0] op, input logic [7:0] cnt);
        @(posedge ref_clk);
        cmdValid <= 1'b1;
        cmdIn <= '{code: op, count: cnt};
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        // stale fields inverted so the design cannot lean on them
        cmdIn <= ~cmdIn;
    endtask

    // any drive access, one-cycle pulse
    task automatic touch();
        @(posedge ref_clk);
        hostAccess <= 1'b1;
        @(posedge ref_clk);
        hostAccess <= 1'b0;
    endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    n_fail++; $display("CHECK FAILED t=%0t got %0h exp %0h", $time, \
    (a), (e)); end end

module tb;
    typedef struct packed {
        logic [31:0] val;
        logic        slack;
    } idst_exp_t;

    logic               ref_clk = 1'b0;
    logic               rstn = 1'b0;
    logic               spindleSpinning = 1'b0;
    logic [7:0]         regAddr = 8'h00;
    logic [31:0]        regWdata = 32'h0;
    logic               regWr = 1'b0;
    logic               regRd = 1'b0;
    logic [7:0]         idAddr = 8'h00;
    logic               idRd = 1'b0;
    logic               cmdValid, hostAccess, cmdDone, spinUpStart;
    logic               motorOn, idleMode, irq;
    idst_pkg::idst_tf_t cmdIn;
    logic [31:0]        regRdata;
    logic [15:0]        idData;
    logic [7:0]         tfStatus, tfError, sum;
    logic [1:0]         rdKind = 2'b00;
    logic [31:0]        sLo, sHi;
    logic [7:0]         pre;
    int                 n_fail = 0;
    int                 samples_checked = 0;
    int                 cyc = 0;
    int                 seed = 32'h56BC522B;
    int                 i;
    idst_exp_t          expQ[$];
    logic [7:0]         codes[7] = '{8'h01, 8'hF0, 8'hF1, 8'hFB, 8'hFC,
                                     8'hFD, 8'hFF};
    int                 secs[7] = '{1*5, 240*5, 1*30*60, 11*30*60, 21*60,
                                    8*60*60, 21*60+15};
    logic [7:0]         wNum[10] = '{8'd209, 8'd210, 8'd217, 8'd219,
                                     8'd220, 8'd222, 8'd223, 8'd234,
                                     8'd235, 8'd207};
    logic [15:0]        wVal[10] = '{16'h4000, 16'h0000, 16'h1C20,
                                     16'h0000, 16'h0000, 16'h107F,
                                     16'h0021, 16'h0008, 16'h0000,
                                     16'h0000};

    always #2.5 ref_clk = ~ref_clk;

    idst_host_model i_host (
        .ref_clk    (ref_clk),
        .cmdIn      (cmdIn),
        .cmdValid   (cmdValid),
        .hostAccess (hostAccess)
    );

    // short tick keeps the code-1 countdown within a few dozen cycles
    idst_cmd #(.TICK_CYCLES(8)) i_dut (
        .ref_clk(ref_clk), .rstn(rstn), .cmdValid(cmdValid),
        .cmdIn(cmdIn), .hostAccess(hostAccess),
        .spindleSpinning(spindleSpinning), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .idAddr(idAddr), .idRd(idRd),
        .idData(idData), .tfStatus(tfStatus), .tfError(tfError),
        .cmdDone(cmdDone), .spinUpStart(spinUpStart), .motorOn(motorOn),
        .idleMode(idleMode), .irq(irq)
    );

    // slack allows one tick to land between load and read
    task automatic pop(input logic [31:0] act);
        idst_exp_t e;
        // nothing expected: force a mismatch
        e = '{~act, 1'b0};
        if (expQ.size() > 0) e = expQ.pop_front();
        `CHK(act, (e.slack && act === e.val - 32'h1) ? act : e.val)
    endtask

    // results appear a cycle after their strobe; old values seen here
    always @(posedge ref_clk) begin
        rdKind <= {idRd, regRd};
        if (rdKind[0]) pop(regRdata);
        if (rdKind[1]) pop({16'h0000, idData});
        if (cmdDone === 1'b1) pop({27'h0, spinUpStart, idleMode, motorOn,
                                    tfError[2], tfStatus[0]});
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic s);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        expQ.push_back('{e, s});
        @(posedge ref_clk);
        regRd <= 1'b0;
    endtask

    task automatic idr(input logic [7:0] w, input logic [15:0] e);
        @(posedge ref_clk);
        idAddr <= w;
        idRd <= 1'b1;
        expQ.push_back('{{16'h0000, e}, 1'b0});
        @(posedge ref_clk);
        idRd <= 1'b0;
    endtask

    // e = {spinUp, idle, motor, rejected, status error}
    task automatic cmd(input logic [7:0] op, input logic [7:0] cnt,
                       input logic [4:0] e);
        expQ.push_back('{{27'h0, e}, 1'b0});
        i_host.issue(op, cnt);
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // hang guard well above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        for (i = 0; i < 5; i++) rd(8'(i * 4), 32'h0, 1'b0);
        rd(8'h40, 32'h0, 1'b0);
        $display("test reset values done");
        // range ends and fixed timeout codes, alternating the two opcodes
        for (i = 0; i < 7; i++) begin
            cmd(i[0] ? 8'h97 : 8'hE3, codes[i],
                i == 0 ? 5'b11100 : 5'b01100);
            rd(8'h10, 32'(secs[i]), 1'b1);
            spindleSpinning <= 1'b1;
            // two sync stages before the design sees the spindle turn
            if (i == 0) repeat (2) @(posedge ref_clk);
        end
        $display("test timeout codes done");
        cmd(8'hE3, 8'hFE, 5'b01111);
        rd(8'h0C, 32'hF, 1'b0);
        cmd(8'hE1, 8'h01, 5'b00000);
        void'(expQ.pop_back());
        repeat (3) @(posedge ref_clk);
        cmd(8'h97, 8'h00, 5'b01100);
        repeat (60) @(posedge ref_clk);
        rd(8'h0C, 32'hD, 1'b0);
        $display("test reject and disable done");
        wr(8'h04, 32'h7);
        wr(8'h08, 32'h4);
        cmd(8'hE3, 8'h01, 5'b01100);
        for (i = 0; i < 60 && idleMode !== 1'b0; i++) @(negedge ref_clk);
        @(negedge ref_clk);
        `CHK(i > 30, 1'b1)
        `CHK({irq, motorOn}, 2'b10)
        `CHK({tfStatus, tfError}, 16'h5000)
        rd(8'h0C, 32'hA, 1'b0);
        rd(8'h04, 32'h5, 1'b0);
        wr(8'h08, 32'h0);
        @(negedge ref_clk);
        `CHK(irq, 1'b0)
        wr(8'h08, 32'h4);
        wr(8'h04, 32'h4);
        @(negedge ref_clk);
        `CHK(irq, 1'b0)
        rd(8'h04, 32'h1, 1'b0);
        $display("test expiry and interrupt done");
        cmd(8'hE3, 8'h01, 5'b01100);
        repeat (26) @(posedge ref_clk);
        i_host.touch();
        rd(8'h10, 32'h5, 1'b1);
        repeat (26) @(negedge ref_clk);
        `CHK(idleMode, 1'b1)
        $display("test access reload done");
        sLo = $random(seed);
        sHi = $random(seed);
        pre = 8'($random(seed));
        wr(8'h14, sLo);
        wr(8'h18, sHi);
        wr(8'h1C, {24'h0, pre});
        for (i = 0; i < 10; i++) idr(wNum[i], wVal[i]);
        idr(8'd230, sLo[15:0]);
        idr(8'd231, sLo[31:16]);
        idr(8'd232, sHi[15:0]);
        idr(8'd233, sHi[31:16]);
        for (i = 1; i < 4; i++) begin
            wr(8'h00, 32'(i));
            idr(8'd217, i == 1 ? 16'h1644 : i == 2 ? 16'h1734
                : 16'h1C20);
        end
        sum = pre + 8'h40 + 8'h1C + 8'h20 + 8'h10 + 8'h7F + 8'h21
            + 8'h08 + 8'hA5;
        for (i = 0; i < 4; i++) sum = sum + sLo[i*8 +: 8] + sHi[i*8 +: 8];
        idr(8'd255, {8'h00 - sum, 8'hA5});
        repeat (3) @(posedge ref_clk);
        $display("test identify words done");
        give_verdict();
    end
endmodule
